// ### rtl/adc_sel_pkg.sv
package adc_sel_pkg;
  // converter clock is the reference clock divided by this count
  localparam int unsigned ADC_DIV      = 4;
  localparam int unsigned DIV_W        = 2;
  localparam int unsigned CNT_W        = 5;
  localparam logic [CNT_W-1:0] LEN_FIRST  = 5'h19;
  localparam logic [CNT_W-1:0] LEN_NORMAL = 5'h0d;
  localparam int unsigned CH_W         = 5;
  localparam int unsigned REF_W        = 2;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned LVL_W        = 11;
  localparam logic [RES_W-1:0] CODE_MAX = 10'h3ff;

  // reference sources
  localparam logic [REF_W-1:0] REF_EXT_PIN = 2'h0;
  localparam logic [REF_W-1:0] REF_SUPPLY  = 2'h1;
  localparam logic [REF_W-1:0] REF_INT_LOW = 2'h2;
  localparam logic [REF_W-1:0] REF_INT_HI  = 2'h3;

  // sleep modes
  localparam logic [1:0] SLEEP_NONE  = 2'h0;
  localparam logic [1:0] SLEEP_IDLE  = 2'h1;
  localparam logic [1:0] SLEEP_NOISE = 2'h2;
  localparam logic [1:0] SLEEP_DEEP  = 2'h3;

  // controller registers, byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SEL    = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MK = 8'h14;

  // field positions
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_ATE   = 1;
  localparam int unsigned CTRL_FREE  = 2;
  localparam int unsigned CTRL_IE    = 3;
  localparam int unsigned CTRL_SLP   = 4;
  localparam int unsigned SEL_CH     = 0;
  localparam int unsigned SEL_REF    = 8;
  localparam int unsigned CMD_START  = 0;
  localparam int unsigned CMD_CLR    = 1;
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_ACH     = 8;
  localparam int unsigned ST_EXTERNAL_REFERENCE_PIN    = 13;
  localparam int unsigned ST_RES     = 16;
  localparam int unsigned EV_DONE    = 0;
  localparam int unsigned EV_EARLY   = 1;
  localparam int unsigned EV_W       = 2;
endpackage

// ### rtl/adc_sel_if.sv
`timescale 1ns/1ps
interface adc_sel_if;
  import adc_sel_pkg::*;
  logic              sel_wr;
  logic [CH_W-1:0]   sel_ch;
  logic [REF_W-1:0]  sel_ref;
  logic              enable;
  logic              auto_trig;
  logic              free_run;
  logic              start;
  logic              trigger;
  logic [1:0]        sleep_mode;
  logic              cpu_halted;
  logic              done_clr;
  logic              busy;
  logic              done;
  logic [CH_W-1:0]   act_ch;
  logic [REF_W-1:0]  act_ref;
  logic [RES_W-1:0]  result;

  modport dev (input sel_wr, sel_ch, sel_ref, enable, auto_trig, free_run, start, trigger,
               sleep_mode, cpu_halted, done_clr,
               output busy, done, act_ch, act_ref, result);
  modport ctl (output sel_wr, sel_ch, sel_ref, enable, auto_trig, free_run, start, trigger,
               sleep_mode, cpu_halted, done_clr,
               input busy, done, act_ch, act_ref, result);
endinterface

// ### rtl/adc_sel_dev.sv
// Functional notes
// - temp selection copied to active while idle
// - active selection frozen during conversion
// - copying resumes in last converter cycle
// - start taken on next converter clock edge
// - software waits one converter cycle before reselect
// - auto-trigger reselect only in three safe windows
// - safely written selection applies to next conversion
// - free-run change skips already started conversion
// - software selects channel before first start
// - software discards first result after reference switch
// - four reference sources selectable
// - noise or idle sleep starts conversion on halt while auto-trigger is off
// - software prepares converter before noise sleep
// - sleep conversion completes despite early wake
// - deep sleep leaves converter enabled
// - over-range input saturates to maximum code
// - result code spans zero to full scale
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module adc_sel_dev
  import adc_sel_pkg::*;
(
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_nrst,
  adc_sel_if.dev                             bus,
  input  wire logic [adc_sel_pkg::LVL_W-1:0] i_level,
  output logic [adc_sel_pkg::CH_W-1:0]       o_channel_select,
  output logic [adc_sel_pkg::REF_W-1:0]      o_reference_select,
  output logic                               o_converting
);
  import adc_sel_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } state_e;

  // whole state of the converter end, held in one register
  typedef struct packed {
    state_e            state;
    logic              conv;
    logic [DIV_W-1:0]  div;
    logic [CNT_W-1:0]  cyc;
    logic [CNT_W-1:0]  len;
    logic              first;
    logic              pend;
    logic              trig_q;
    logic              halt_q;
    logic [CH_W-1:0]   tmp_ch;
    logic [REF_W-1:0]  tmp_ref;
    logic [CH_W-1:0]   ch;
    logic [REF_W-1:0]  refs;
    logic              busy;
    logic              done;
    logic [RES_W-1:0]  result;
  } st_s;

  st_s st_q;
  st_s st_d;

  // idle and noise sleep both start a conversion on halt while auto trigger is off
  function automatic logic sleep_start_mode(input logic [1:0] mode);
    sleep_start_mode = (mode == SLEEP_IDLE) || (mode == SLEEP_NOISE);
  endfunction

  // the first conversion after enable runs longer to settle the analog side
  function automatic logic [CNT_W-1:0] conv_len(input logic first_conv);
    conv_len = first_conv ? LEN_FIRST : LEN_NORMAL;
  endfunction

  // a trigger or sleep start is only taken while nothing is pending or converting
  function automatic logic can_start(input state_e s, input logic pending);
    can_start = (s == ST_IDLE) && !pending;
  endfunction

  // saturating conversion of the input level
  function automatic logic [RES_W-1:0] to_code(input logic [LVL_W-1:0] lvl);
    if (lvl[LVL_W-1]) begin
      to_code = CODE_MAX;
    end else begin
      to_code = lvl[RES_W-1:0];
    end
  endfunction

  logic tick;
  logic last_cyc;
  logic trig_edge;
  logic sleep_go;
  logic done_ev;
  logic trig_start;
  logic start_req;
  logic lock_open;

  always_comb begin
    st_d = st_q;
    tick = (st_q.div == DIV_W'(ADC_DIV - 1));
    last_cyc = (st_q.state == ST_CONV) && (st_q.cyc == st_q.len - CNT_W'(1));
    // auto trigger acts on a rising edge only, and never in free run
    trig_edge = bus.trigger && !st_q.trig_q && bus.auto_trig && !bus.free_run;
    // an edge that finds the converter busy is dropped, not queued
    trig_start = trig_edge && can_start(st_q.state, st_q.pend);
    // sleep only ever starts conversions; enable stays with software
    sleep_go = sleep_start_mode(bus.sleep_mode) && bus.cpu_halted && !st_q.halt_q &&
               !bus.auto_trig && can_start(st_q.state, st_q.pend);
    start_req = bus.start || sleep_go;
    // lock opens again for the whole final converter cycle
    lock_open = (st_q.state == ST_IDLE) || last_cyc;
    done_ev = 1'b0;
    st_d.trig_q = bus.trigger;
    st_d.halt_q = bus.cpu_halted;
    st_d.div = tick ? '0 : st_q.div + DIV_W'(1);

    // whole field pair taken in one write
    if (bus.sel_wr) begin
      st_d.tmp_ch = bus.sel_ch;
      st_d.tmp_ref = bus.sel_ref;
    end

    // active selection follows temp unless locked
    if (lock_open) begin
      st_d.ch = st_d.tmp_ch;
      st_d.refs = st_d.tmp_ref;
    end

    // disabling aborts and rearms the long first conversion
    if (!bus.enable) begin
      st_d.state = ST_IDLE;
      st_d.div = '0;
      st_d.first = 1'b1;
      st_d.pend = 1'b0;
      st_d.busy = 1'b0;
    end else begin
      if (start_req) begin
        st_d.pend = 1'b1;
        st_d.busy = 1'b1;
      end
      // prescaler restarts so the trigger to sample delay is fixed
      if (trig_start) begin
        st_d.pend = 1'b1;
        st_d.busy = 1'b1;
        st_d.div = '0;
      end
      case (st_q.state)
        ST_IDLE: begin
          if (st_q.pend && tick) begin
            st_d.state = ST_CONV;
            st_d.pend = 1'b0;
            st_d.cyc = '0;
            st_d.len = conv_len(st_q.first);
            st_d.first = 1'b0;
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (last_cyc) begin
              // result and completion flag land at the same tick
              done_ev = 1'b1;
              st_d.result = to_code(i_level);
              // free run restarts at once, so the lock closes again
              if (bus.auto_trig && bus.free_run) begin
                st_d.cyc = '0;
                st_d.len = conv_len(1'b0);
              end else begin
                st_d.state = ST_IDLE;
                st_d.busy = st_d.pend;
              end
            end else begin
              st_d.cyc = st_q.cyc + CNT_W'(1);
            end
          end
        end
        default: begin
          st_d.state = ST_IDLE;
        end
      endcase
    end

    // set wins over clear
    if (done_ev) begin
      st_d.done = 1'b1;
    end else if (bus.done_clr) begin
      st_d.done = 1'b0;
    end

    // registered state decode drives the converting pin
    st_d.conv = (st_d.state == ST_CONV);
  end // sleep mode never touches enable

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      // reset rearms the long first conversion
      st_q <= '{state: ST_IDLE, first: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.busy = st_q.busy;
  assign bus.done = st_q.done;
  assign bus.act_ch = st_q.ch;
  assign bus.act_ref = st_q.refs;
  assign bus.result = st_q.result;

  // pins come straight from the state register
  assign o_channel_select = st_q.ch;
  assign o_reference_select = st_q.refs;
  assign o_converting = st_q.conv;
endmodule

// ### rtl/adc_sel_ctl.sv
`timescale 1ns/1ps
module adc_sel_ctl
  import adc_sel_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  adc_sel_if.ctl           bus,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_trigger,
  input  wire logic        i_cpu_halted,
  output logic             o_irq
);
  import adc_sel_pkg::*;

  typedef struct packed {
    logic              en;
    logic              ate;
    logic              free;
    logic              ie;
    logic [1:0]        slp;
    logic [CH_W-1:0]   ch;
    logic [REF_W-1:0]  refs;
    logic              sel_wr;
    logic              start;
    logic              clr;
    logic              trig;
    logic              halted;
    logic              done_q;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   mask;
    logic              ready;
    logic              err;
    logic [31:0]       rdata;
    logic              irq;
  } st_s;

  st_s st_q;
  st_s st_d;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_SEL) || (a == OFS_CMD) ||
             (a == OFS_STATUS) || (a == OFS_IRQ_ST) || (a == OFS_IRQ_MK);
  endfunction

  logic            acc;
  logic            wr;
  logic [EV_W-1:0] ev_set;
  logic [31:0]     rd;

  always_comb begin
    st_d = st_q;
    acc = i_psel && i_penable;
    wr = acc && st_q.ready && i_pwrite && mapped(i_paddr);
    ev_set = '0;
    ev_set[EV_DONE] = bus.done && !st_q.done_q;
    // reselect while busy risks hitting a conversion
    ev_set[EV_EARLY] = wr && (i_paddr == OFS_SEL) && bus.busy &&
                       !(bus.auto_trig && bus.done);
    st_d.sel_wr = 1'b0;
    st_d.start = 1'b0;
    st_d.clr = 1'b0;
    st_d.trig = i_trigger;
    st_d.halted = i_cpu_halted;
    st_d.done_q = bus.done;

    rd = '0;
    case (i_paddr)
      OFS_CTRL: begin
        rd[CTRL_EN] = st_q.en;
        rd[CTRL_ATE] = st_q.ate;
        rd[CTRL_FREE] = st_q.free;
        rd[CTRL_IE] = st_q.ie;
        rd[CTRL_SLP +: 2] = st_q.slp;
      end
      OFS_SEL: begin
        rd[SEL_CH +: CH_W] = st_q.ch;
        rd[SEL_REF +: REF_W] = st_q.refs;
      end
      OFS_STATUS: begin
        rd[ST_BUSY] = bus.busy;
        rd[ST_DONE] = bus.done;
        rd[ST_ACH +: CH_W] = bus.act_ch;
        rd[ST_EXTERNAL_REFERENCE_PIN +: REF_W] = bus.act_ref;
        rd[ST_RES +: RES_W] = bus.result;
      end
      OFS_IRQ_ST: rd[EV_W-1:0] = st_q.ev;
      OFS_IRQ_MK: rd[EV_W-1:0] = st_q.mask;
      default: rd = '0;
    endcase

    // one wait state, answer on the second access cycle
    if (acc && !st_q.ready) begin
      st_d.ready = 1'b1;
      st_d.err = !mapped(i_paddr);
      st_d.rdata = i_pwrite ? 32'h0 : rd;
    end else begin
      st_d.ready = 1'b0;
      st_d.err = 1'b0;
    end

    if (wr) begin
      case (i_paddr)
        OFS_CTRL: begin
          st_d.en = i_pwdata[CTRL_EN];
          st_d.ate = i_pwdata[CTRL_ATE];
          st_d.free = i_pwdata[CTRL_FREE];
          st_d.ie = i_pwdata[CTRL_IE];
          st_d.slp = i_pwdata[CTRL_SLP +: 2];
        end
        OFS_SEL: begin
          st_d.ch = i_pwdata[SEL_CH +: CH_W];
          st_d.refs = i_pwdata[SEL_REF +: REF_W];
          st_d.sel_wr = 1'b1;
        end
        OFS_CMD: begin
          st_d.start = i_pwdata[CMD_START];
          st_d.clr = i_pwdata[CMD_CLR];
        end
        OFS_IRQ_MK: st_d.mask = i_pwdata[EV_W-1:0];
        default: st_d.ev = st_q.ev;
      endcase
    end

    // set wins over write-one clear
    if (wr && i_paddr == OFS_IRQ_ST) begin
      st_d.ev = (st_q.ev & ~i_pwdata[EV_W-1:0]) | ev_set;
    end else begin
      st_d.ev = st_q.ev | ev_set;
    end
    st_d.irq = |(st_d.ev & st_d.mask);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.sel_wr = st_q.sel_wr;
  assign bus.sel_ch = st_q.ch;
  assign bus.sel_ref = st_q.refs;
  assign bus.enable = st_q.en;
  assign bus.auto_trig = st_q.ate;
  assign bus.free_run = st_q.free;
  assign bus.start = st_q.start;
  assign bus.trigger = st_q.trig;
  assign bus.sleep_mode = st_q.slp;
  assign bus.cpu_halted = st_q.halted;
  assign bus.done_clr = st_q.clr;
  assign o_pready = st_q.ready;
  assign o_prdata = st_q.rdata;
  assign o_pslverr = st_q.err;
  assign o_irq = st_q.irq;
endmodule

// ### testbench/adc_sel_chk.sv
`timescale 1ns/1ps
module adc_sel_chk
  import adc_sel_pkg::*;
(
  input wire logic                         i_ref_clk,
  input wire logic                         i_nrst,
  input wire logic                         sel_wr,
  input wire logic [adc_sel_pkg::CH_W-1:0]  sel_ch,
  input wire logic [adc_sel_pkg::REF_W-1:0] sel_ref,
  input wire logic                         enable,
  input wire logic                         auto_trig,
  input wire logic                         free_run,
  input wire logic                         start,
  input wire logic [1:0]                   sleep_mode,
  input wire logic                         cpu_halted,
  input wire logic                         busy,
  input wire logic                         done,
  input wire logic [adc_sel_pkg::CH_W-1:0]  act_ch,
  input wire logic [adc_sel_pkg::REF_W-1:0] act_ref
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_idle; !busy [*4]; endsequence
  sequence s_run; (busy && !done) [*8]; endsequence
  AST_IDLE_FOLLOW: assert property (
    sel_wr && enable && !busy ##1 s_idle |-> act_ch == sel_ch && act_ref == sel_ref)
    else $error("selection not followed while idle");
  AST_LOCKED: assert property (
    sel_wr && busy && $past(busy, 5) ##1 s_run |->
      $past(act_ch, 4) == $past(act_ch, 8) && $past(act_ref, 4) == $past(act_ref, 8))
    else $error("selection changed during conversion");
  AST_START_BUSY: assert property (
    start && enable |=> busy)
    else $error("start not taken");
  AST_CONV_LEN: assert property (
    $rose(busy) && !done |-> ##[50:106] (done || !enable))
    else $error("conversion did not complete in time");
  AST_DONE_SEL: assert property (
    $rose(done) && !sel_wr && !$past(sel_wr) && !$past(sel_wr, 2) |=>
      act_ch == sel_ch && act_ref == sel_ref)
    else $error("selection not taken over at completion");
  AST_FREE_RESTART: assert property (
    $rose(done) && free_run && auto_trig && enable |-> busy)
    else $error("free run did not restart");
  AST_SLEEP_START: assert property (
    $rose(cpu_halted) && enable && !auto_trig && !busy &&
      (sleep_mode == SLEEP_IDLE || sleep_mode == SLEEP_NOISE) |-> ##[1:4] busy)
    else $error("no conversion on halt");
  AST_WAKE_DONE: assert property (
    $fell(cpu_halted) && busy && !done |-> ##[1:106] (done || !enable))
    else $error("sleep conversion not completed");
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import adc_sel_pkg::*;
  logic             i_ref_clk = 0;
  logic             i_nrst = 0;
  logic             i_psel = 0;
  logic             i_penable = 0;
  logic             i_pwrite = 0;
  logic             i_cpu_halted = 0;
  logic [7:0]       i_paddr = '0;
  logic [31:0]      i_pwdata = '0;
  logic [LVL_W-1:0] i_level = '0;
  logic             o_pready, o_pslverr, o_irq, err;
  logic [31:0]      o_prdata, rd;
  logic             i_trigger = 0;
  logic             o_converting;
  logic [CH_W-1:0]  o_channel_select;
  logic [REF_W-1:0] o_reference_select;
  int               bad_count = 0;
  int               samples_checked = 0;
  int               cycles = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  adc_sel_if adc_sel_if_inst ();
  adc_sel_dev adc_sel_dev_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .bus(adc_sel_if_inst),
    .i_level(i_level), .o_channel_select(o_channel_select),
    .o_reference_select(o_reference_select), .o_converting(o_converting));
  adc_sel_ctl adc_sel_ctl_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .bus(adc_sel_if_inst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_trigger(i_trigger), .i_cpu_halted(i_cpu_halted), .o_irq(o_irq));
  adc_sel_chk adc_sel_chk_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .sel_wr(adc_sel_if_inst.sel_wr), .sel_ch(adc_sel_if_inst.sel_ch),
    .sel_ref(adc_sel_if_inst.sel_ref), .enable(adc_sel_if_inst.enable),
    .auto_trig(adc_sel_if_inst.auto_trig), .free_run(adc_sel_if_inst.free_run),
    .start(adc_sel_if_inst.start), .sleep_mode(adc_sel_if_inst.sleep_mode),
    .cpu_halted(adc_sel_if_inst.cpu_halted), .busy(adc_sel_if_inst.busy),
    .done(adc_sel_if_inst.done), .act_ch(adc_sel_if_inst.act_ch),
    .act_ref(adc_sel_if_inst.act_ref));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(negedge i_ref_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    @(posedge i_ref_clk);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, '0);
      n++;
    end while (rd[ST_DONE] !== 1'b1 && n < 100);
    chk("done", 32'h1, 32'(rd[ST_DONE]));
  endtask

  task automatic t_select();
    apb(1'b1, OFS_CTRL, 32'h1);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, OFS_SEL, 32'(r) << SEL_REF | 32'(r * 7 + 3));
      repeat (4) @(posedge i_ref_clk);
      apb(1'b0, OFS_STATUS, '0);
      chk("act_ch", 32'(r * 7 + 3), 32'(rd[ST_EXTERNAL_REFERENCE_PIN-1:ST_ACH]));
      chk("act_ref", 32'(r), 32'(rd[ST_EXTERNAL_REFERENCE_PIN+1:ST_EXTERNAL_REFERENCE_PIN]));
      chk("out_ch", 32'(r * 7 + 3), 32'(o_channel_select));
      chk("out_ref", 32'(r), 32'(o_reference_select));
    end
    apb(1'b1, OFS_CMD, 32'h1);
    wait_done();
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_IRQ_ST, 32'h3);
    apb(1'b0, 8'h20, '0);
    chk("pslverr", 32'h1, 32'(err));
    $display("test select finished");
  endtask

  task automatic t_conv(input logic [LVL_W-1:0] l, input logic [RES_W-1:0] e, input logic m);
    i_level <= l;
    apb(1'b1, OFS_IRQ_MK, {30'h0, m, m});
    apb(1'b1, OFS_SEL, 32'h5);
    apb(1'b1, OFS_CMD, 32'h1);
    repeat (12) @(posedge i_ref_clk);
    apb(1'b1, OFS_SEL, 32'h9);
    apb(1'b0, OFS_STATUS, '0);
    chk("locked_ch", 32'h5, 32'(rd[ST_EXTERNAL_REFERENCE_PIN-1:ST_ACH]));
    chk("irq_reselect", 32'(m), 32'(o_irq));
    chk("converting", 32'h1, 32'(o_converting));
    wait_done();
    chk("next_ch", 32'h9, 32'(rd[ST_EXTERNAL_REFERENCE_PIN-1:ST_ACH]));
    chk("result", 32'(e), 32'(rd[ST_RES+9:ST_RES]));
    chk("idle_after", 32'h0, 32'(o_converting));
    apb(1'b0, OFS_IRQ_ST, '0);
    chk("irq_status", 32'h3, rd);
    apb(1'b1, OFS_IRQ_ST, 32'h3);
    apb(1'b1, OFS_CMD, 32'h2);
    chk("irq_cleared", 32'h0, 32'(o_irq));
    $display("test conversion finished");
  endtask

  task automatic t_free();
    apb(1'b1, OFS_CTRL, 32'h7);
    apb(1'b1, OFS_CMD, 32'h1);
    wait_done();
    apb(1'b1, OFS_SEL, 32'h2);
    apb(1'b1, OFS_CMD, 32'h2);
    wait_done();
    chk("free_busy", 32'h1, 32'(rd[ST_BUSY]));
    chk("free_ch", 32'h2, 32'(rd[ST_EXTERNAL_REFERENCE_PIN-1:ST_ACH]));
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CMD, 32'h2);
    wait_done();
    chk("free_stop", 32'h0, 32'(rd[ST_BUSY]));
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_IRQ_ST, 32'h3);
    $display("test free run finished");
  endtask

  task automatic t_trig();
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b1, OFS_SEL, 32'h4);
    i_trigger <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    apb(1'b1, OFS_SEL, 32'h6);
    apb(1'b0, OFS_STATUS, '0);
    chk("trig_busy", 32'h1, 32'(rd[ST_BUSY]));
    chk("trig_ch", 32'h4, 32'(rd[ST_EXTERNAL_REFERENCE_PIN-1:ST_ACH]));
    wait_done();
    chk("trig_next_ch", 32'h6, 32'(rd[ST_EXTERNAL_REFERENCE_PIN-1:ST_ACH]));
    repeat (8) @(posedge i_ref_clk);
    apb(1'b0, OFS_STATUS, '0);
    chk("trig_held", 32'h0, 32'(rd[ST_BUSY]));
    i_trigger <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CMD, 32'h2);
    apb(1'b1, OFS_IRQ_ST, 32'h3);
    $display("test trigger finished");
  endtask

  task automatic t_sleep(input logic [1:0] m, input logic b);
    apb(1'b1, OFS_IRQ_MK, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h9 | 32'(m) << CTRL_SLP);
    i_cpu_halted <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    apb(1'b0, OFS_STATUS, '0);
    chk("sleep_busy", 32'(b), 32'(rd[ST_BUSY]));
    i_cpu_halted <= 1'b0;
    apb(1'b0, OFS_CTRL, '0);
    chk("enable", 32'h1, 32'(rd[CTRL_EN]));
    if (b) begin
      wait_done();
      chk("irq_done", 32'h1, 32'(o_irq));
      apb(1'b1, OFS_IRQ_ST, 32'h3);
      apb(1'b1, OFS_CMD, 32'h2);
    end
    $display("test sleep finished");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    t_select();
    t_conv(11'h000, 10'h000, 1'b1);
    t_conv(11'h3ff, 10'h3ff, 1'b1);
    t_conv(11'h7ff, CODE_MAX, 1'b0);
    t_free();
    t_trig();
    t_sleep(SLEEP_IDLE, 1'b1);
    t_sleep(SLEEP_NOISE, 1'b1);
    t_sleep(SLEEP_DEEP, 1'b0);
    print_verdict();
  end
endmodule
